// [verilog/gcw_top.sv]
// Eight-pin general purpose port: configuration, wake detection, events
//
// Operation
// - Function-select bit zero puts the pin in general purpose mode.
// - Drive-type bit one gives push/pull, zero gives open-drain output.
// - Direction bit one makes the pin an output, zero an input.
// - Output pins drive the level bit, open-drain ones only when it is zero; reads return the live pin level.
// - Function select defaults to image, else all ones.
// - Drive, direction and level default to image, else zero.
// - USB or lite soft reset restores last loaded image or fixed defaults.
// - Level bit of an input pin after reset has no defined value.
// - Reset protection keeps all pin fields unchanged over protected resets.
// - Wake-enable bit one lets its pin raise wake, zero blocks it.
// - Polarity bit picks low or high pin level as trigger.
// - Pins outside general purpose mode never produce a wake event.
// - Wake fields load from image bytes, else default to zero.
`default_nettype none
module gcw_top
  import gcw_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire logic [ADDR_W-1:0]   REG_ADDR,
  input  wire logic [DATA_W-1:0]   REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic      [DATA_W-1:0]   REG_RDATA,
  input  wire logic                IMG_LOAD,
  input  wire logic [NUM_PINS-1:0] IMG_FUNC,
  input  wire logic [NUM_PINS-1:0] IMG_DRIVE,
  input  wire logic [NUM_PINS-1:0] IMG_DIR,
  input  wire logic [NUM_PINS-1:0] IMG_LEVEL,
  input  wire logic [NUM_PINS-1:0] IMG_WK_EN,
  input  wire logic [NUM_PINS-1:0] IMG_WK_POL,
  input  wire logic                USB_RESET,
  input  wire logic                LITE_SOFT_RESET,
  input  wire logic                RESET_PROTECT,
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output logic      [NUM_PINS-1:0] PIN_OUT,
  output logic      [NUM_PINS-1:0] PIN_OE_N,
  output logic                     WAKE_EVENT,
  output logic                     IRQ
);
  default clocking dcb_sys @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  logic [NUM_PINS-1:0] pin_function_select_r;
  logic [NUM_PINS-1:0] output_drive_type_r;
  logic [NUM_PINS-1:0] pin_direction_r;
  logic [NUM_PINS-1:0] pin_level_r;
  logic [NUM_PINS-1:0] wake_enable_mask_r;
  logic [NUM_PINS-1:0] wake_polarity_r;
  logic [NUM_PINS-1:0] img_func_r;
  logic [NUM_PINS-1:0] img_drive_r;
  logic [NUM_PINS-1:0] img_dir_r;
  logic [NUM_PINS-1:0] img_level_r;
  logic [NUM_PINS-1:0] img_wk_en_r;
  logic [NUM_PINS-1:0] img_wk_pol_r;
  logic                img_valid_r;
  logic [NUM_PINS-1:0] status_r;
  logic [NUM_PINS-1:0] status_nxt;
  logic [NUM_PINS-1:0] mask_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                wake_r;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] gpio_input;
  logic [NUM_PINS-1:0] pol_match;
  logic [NUM_PINS-1:0] wake_src;
  logic                restore;
  logic                wr_lo;
  logic                wr_up;
  logic                wr_wk;
  logic                wr_sts;
  logic                wr_msk;

  gcw_sync #(.WIDTH (NUM_PINS)) u_sync (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .async_in (PIN_IN),
    .sync_out (pin_sync)
  );

  assign restore = (USB_RESET | LITE_SOFT_RESET) & ~RESET_PROTECT;
  assign wr_lo   = REG_WR && (REG_ADDR == PIN_CONFIG_LOWER_OFS);
  assign wr_up   = REG_WR && (REG_ADDR == PIN_CONFIG_UPPER_OFS);
  assign wr_wk   = REG_WR && (REG_ADDR == PIN_WAKE_ENABLE_POLARITY_OFS);
  assign wr_sts  = REG_WR && (REG_ADDR == PIN_EVENT_STATUS_OFS);
  assign wr_msk  = REG_WR && (REG_ADDR == PIN_EVENT_MASK_OFS);

  // Last loaded image is kept so a later bus reset can return to it
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      img_valid_r  <= 1'b0;
      img_func_r   <= FUNC_DEFAULT;
      img_drive_r  <= DRIVE_DEFAULT;
      img_dir_r    <= DIR_DEFAULT;
      img_level_r  <= LEVEL_DEFAULT;
      img_wk_en_r  <= WK_EN_DEFAULT;
      img_wk_pol_r <= WK_POL_DEFAULT;
    end else if (IMG_LOAD) begin
      img_valid_r  <= 1'b1;
      img_func_r   <= IMG_FUNC;
      img_drive_r  <= IMG_DRIVE;
      img_dir_r    <= IMG_DIR;
      img_level_r  <= IMG_LEVEL;
      img_wk_en_r  <= IMG_WK_EN;
      img_wk_pol_r <= IMG_WK_POL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_function_select_r <= FUNC_DEFAULT;
    end else if (IMG_LOAD) begin
      pin_function_select_r <= IMG_FUNC;
    end else if (restore) begin
      pin_function_select_r <= img_valid_r ? img_func_r : FUNC_DEFAULT;
    end else begin
      if (wr_lo) begin
        pin_function_select_r[HALF_PINS-1:0] <= REG_WDATA[LO_FUNC_LSB +: HALF_PINS];
      end
      if (wr_up) begin
        pin_function_select_r[NUM_PINS-1:HALF_PINS] <= REG_WDATA[UP_FUNC_LSB +: HALF_PINS];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      output_drive_type_r <= DRIVE_DEFAULT;
    end else if (IMG_LOAD) begin
      output_drive_type_r <= IMG_DRIVE;
    end else if (restore) begin
      output_drive_type_r <= img_valid_r ? img_drive_r : DRIVE_DEFAULT;
    end else begin
      if (wr_lo) begin
        output_drive_type_r[HALF_PINS-1:0] <= REG_WDATA[LO_DRIVE_LSB +: HALF_PINS];
      end
      if (wr_up) begin
        output_drive_type_r[NUM_PINS-1:HALF_PINS] <= REG_WDATA[UP_DRIVE_LSB +: HALF_PINS];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_direction_r <= DIR_DEFAULT;
    end else if (IMG_LOAD) begin
      pin_direction_r <= IMG_DIR;
    end else if (restore) begin
      pin_direction_r <= img_valid_r ? img_dir_r : DIR_DEFAULT;
    end else begin
      if (wr_lo) begin
        pin_direction_r[HALF_PINS-1:0] <= REG_WDATA[LO_DIR_LSB +: HALF_PINS];
      end
      if (wr_up) begin
        pin_direction_r[NUM_PINS-1:HALF_PINS] <= REG_WDATA[UP_DIR_LSB +: HALF_PINS];
      end
    end
  end

  // Stored level only matters for outputs; inputs read back the pin
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_level_r <= LEVEL_DEFAULT;
    end else if (IMG_LOAD) begin
      pin_level_r <= IMG_LEVEL;
    end else if (restore) begin
      pin_level_r <= img_valid_r ? img_level_r : LEVEL_DEFAULT;
    end else begin
      if (wr_lo) begin
        pin_level_r[HALF_PINS-1:0] <= REG_WDATA[LO_LEVEL_LSB +: HALF_PINS];
      end
      if (wr_up) begin
        pin_level_r[NUM_PINS-1:HALF_PINS] <= REG_WDATA[UP_LEVEL_LSB +: HALF_PINS];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wake_enable_mask_r <= WK_EN_DEFAULT;
      wake_polarity_r    <= WK_POL_DEFAULT;
    end else if (IMG_LOAD) begin
      wake_enable_mask_r <= IMG_WK_EN;
      wake_polarity_r    <= IMG_WK_POL;
    end else if (restore) begin
      wake_enable_mask_r <= img_valid_r ? img_wk_en_r : WK_EN_DEFAULT;
      wake_polarity_r    <= img_valid_r ? img_wk_pol_r : WK_POL_DEFAULT;
    end else if (wr_wk) begin
      wake_enable_mask_r <= REG_WDATA[WK_EN_LSB +: NUM_PINS];
      wake_polarity_r    <= REG_WDATA[WK_POL_LSB +: NUM_PINS];
    end
  end

  // Pin drivers; a pin in its alternate function is released here
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic drive_on;
      assign drive_on = ~pin_function_select_r[gi] & pin_direction_r[gi];
      // Open-drain only pulls low; a high level relies on the pull-up
      assign PIN_OUT[gi]  = drive_on & output_drive_type_r[gi] & pin_level_r[gi];
      assign PIN_OE_N[gi] = ~(drive_on & (output_drive_type_r[gi] | ~pin_level_r[gi]));
    end
  endgenerate

  // Trigger sources: general purpose input at its selected level
  assign gpio_input = ~pin_function_select_r & ~pin_direction_r;
  assign pol_match  = ~(pin_sync ^ wake_polarity_r);
  assign wake_src   = gpio_input & pol_match & wake_enable_mask_r;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= |wake_src;
    end
  end
  assign WAKE_EVENT = wake_r;

  // Sticky event bits; a new event beats a same-cycle clear
  assign status_nxt = (wr_sts ? (status_r & ~REG_WDATA[EVT_LSB +: NUM_PINS]) : status_r)
                      | (gpio_input & pol_match);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mask_r <= MASK_RESET;
    end else if (wr_msk) begin
      mask_r <= REG_WDATA[EVT_LSB +: NUM_PINS];
    end
  end
  assign IRQ = |(status_r & mask_r);

  // Read mux; reserved and unmapped bits come back zero
  always_comb begin
    rdata_nxt = '0;
    unique case (REG_ADDR)
      PIN_CONFIG_LOWER_OFS: begin
        rdata_nxt[LO_FUNC_LSB +: HALF_PINS]  = pin_function_select_r[HALF_PINS-1:0];
        rdata_nxt[LO_DRIVE_LSB +: HALF_PINS] = output_drive_type_r[HALF_PINS-1:0];
        rdata_nxt[LO_DIR_LSB +: HALF_PINS]   = pin_direction_r[HALF_PINS-1:0];
        rdata_nxt[LO_LEVEL_LSB +: HALF_PINS] = pin_sync[HALF_PINS-1:0];
      end
      PIN_CONFIG_UPPER_OFS: begin
        rdata_nxt[UP_FUNC_LSB +: HALF_PINS]  = pin_function_select_r[NUM_PINS-1:HALF_PINS];
        rdata_nxt[UP_DRIVE_LSB +: HALF_PINS] = output_drive_type_r[NUM_PINS-1:HALF_PINS];
        rdata_nxt[UP_DIR_LSB +: HALF_PINS]   = pin_direction_r[NUM_PINS-1:HALF_PINS];
        rdata_nxt[UP_LEVEL_LSB +: HALF_PINS] = pin_sync[NUM_PINS-1:HALF_PINS];
      end
      PIN_WAKE_ENABLE_POLARITY_OFS: begin
        rdata_nxt[WK_EN_LSB +: NUM_PINS]  = wake_enable_mask_r;
        rdata_nxt[WK_POL_LSB +: NUM_PINS] = wake_polarity_r;
      end
      PIN_EVENT_STATUS_OFS: rdata_nxt[EVT_LSB +: NUM_PINS] = status_r;
      PIN_EVENT_MASK_OFS:   rdata_nxt[EVT_LSB +: NUM_PINS] = mask_r;
      default:              rdata_nxt = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_r <= RDATA_RESET;
    end else begin
      rdata_r <= REG_RD ? rdata_nxt : RDATA_RESET;
    end
  end
  assign REG_RDATA = rdata_r;

  // Checks; clock and reset gating come from the defaults at the top
  property p_func_blocks_drive;
    (pin_function_select_r != 8'h00) |-> ((~PIN_OE_N & pin_function_select_r) == 8'h00);
  endproperty
  a_func_blocks_drive: assert property (p_func_blocks_drive)
    else $error("pin in alternate function is driven");
  property p_open_drain_low;
    ((~PIN_OE_N & ~output_drive_type_r & PIN_OUT) == 8'h00);
  endproperty
  a_open_drain_low: assert property (p_open_drain_low)
    else $error("open-drain pin driven high");
  property p_input_released;
    ((~pin_direction_r & ~PIN_OE_N) == 8'h00);
  endproperty
  a_input_released: assert property (p_input_released)
    else $error("input pin is driven");
  property p_push_pull_level;
    (~pin_function_select_r[0] & pin_direction_r[0] & output_drive_type_r[0])
      |-> (!PIN_OE_N[0] && PIN_OUT[0] == pin_level_r[0]);
  endproperty
  a_push_pull_level: assert property (p_push_pull_level)
    else $error("push-pull pin 0 not at its level bit");
  property p_read_live_level;
    (REG_RD && REG_ADDR == PIN_CONFIG_LOWER_OFS) |=> (REG_RDATA[3:0] == $past(pin_sync[3:0]));
  endproperty
  a_read_live_level: assert property (p_read_live_level)
    else $error("level read does not show the pin");
  // Must watch the reset cycles themselves, so the default gating is switched off
  property p_reset_defaults;
    disable iff (1'b0)
    (!RST_N) |=> (pin_function_select_r == 8'hff && pin_direction_r == 8'h00
                  && output_drive_type_r == 8'h00 && wake_enable_mask_r == 8'h00);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("fixed defaults not applied at reset");
  property p_restore_image;
    (restore && !IMG_LOAD && img_valid_r)
      |=> (pin_function_select_r == $past(img_func_r) && wake_polarity_r == $past(img_wk_pol_r));
  endproperty
  a_restore_image: assert property (p_restore_image)
    else $error("bus reset did not restore the image");
  property p_protect_hold;
    ((USB_RESET || LITE_SOFT_RESET) && RESET_PROTECT && !IMG_LOAD && !REG_WR)
      |=> ($stable(pin_function_select_r) && $stable(pin_direction_r) && $stable(wake_polarity_r));
  endproperty
  a_protect_hold: assert property (p_protect_hold)
    else $error("protected reset changed a field");
  property p_wake_gated;
    ((pin_function_select_r | pin_direction_r | ~wake_enable_mask_r) == 8'hff) |=> !WAKE_EVENT;
  endproperty
  a_wake_gated: assert property (p_wake_gated)
    else $error("wake from a blocked pin");
  property p_wake_raised;
    (~pin_function_select_r[1] & ~pin_direction_r[1] & wake_enable_mask_r[1]
      & (pin_sync[1] == wake_polarity_r[1])) |=> WAKE_EVENT;
  endproperty
  a_wake_raised: assert property (p_wake_raised)
    else $error("pin 1 at its level gave no wake");
  property p_reserved_zero;
    (REG_RD && REG_ADDR == PIN_CONFIG_UPPER_OFS)
      |=> (REG_RDATA[31:28] == 4'h0 && REG_RDATA[23:20] == 4'h0 && REG_RDATA[7:4] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_cov_wake;
    $rose(WAKE_EVENT);
  endproperty
  c_cov_wake: cover property (p_cov_wake);
  property p_cov_restore;
    restore && img_valid_r;
  endproperty
  c_cov_restore: cover property (p_cov_restore);
  property p_cov_irq;
    $rose(IRQ);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule
`default_nettype wire

// [verilog/gcw_pkg.sv]
// Package: register map, field layout and reset values of the pin block
`default_nettype none
package gcw_pkg;
  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned HALF_PINS  = 4;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;

  localparam logic [ADDR_W-1:0] PIN_CONFIG_LOWER_OFS         = 12'h018;
  localparam logic [ADDR_W-1:0] PIN_CONFIG_UPPER_OFS         = 12'h01c;
  localparam logic [ADDR_W-1:0] PIN_WAKE_ENABLE_POLARITY_OFS = 12'h020;
  localparam logic [ADDR_W-1:0] PIN_EVENT_STATUS_OFS         = 12'h060;
  localparam logic [ADDR_W-1:0] PIN_EVENT_MASK_OFS           = 12'h064;

  // Field positions (least significant bit of each 4 or 8 bit field)
  localparam int unsigned LO_FUNC_LSB  = 12;
  localparam int unsigned LO_DRIVE_LSB = 8;
  localparam int unsigned LO_DIR_LSB   = 4;
  localparam int unsigned LO_LEVEL_LSB = 0;
  localparam int unsigned UP_FUNC_LSB  = 24;
  localparam int unsigned UP_DRIVE_LSB = 16;
  localparam int unsigned UP_DIR_LSB   = 8;
  localparam int unsigned UP_LEVEL_LSB = 0;
  localparam int unsigned WK_EN_LSB    = 0;
  localparam int unsigned WK_POL_LSB   = 16;
  localparam int unsigned EVT_LSB      = 0;

  // Fixed defaults when neither a stored image nor a configured OTP exists; event and read data reset values follow
  localparam logic [NUM_PINS-1:0] FUNC_DEFAULT   = 8'hff;
  localparam logic [NUM_PINS-1:0] DRIVE_DEFAULT  = 8'h00;
  localparam logic [NUM_PINS-1:0] DIR_DEFAULT    = 8'h00;
  localparam logic [NUM_PINS-1:0] LEVEL_DEFAULT  = 8'h00;
  localparam logic [NUM_PINS-1:0] WK_EN_DEFAULT  = 8'h00;
  localparam logic [NUM_PINS-1:0] WK_POL_DEFAULT = 8'h00;
  localparam logic [NUM_PINS-1:0] STATUS_RESET   = 8'h00;
  localparam logic [NUM_PINS-1:0] MASK_RESET     = 8'h00;
  localparam logic [DATA_W-1:0]   RDATA_RESET    = 32'h0000_0000;

  localparam int unsigned SYNC_STAGES = 2;
endpackage
`default_nettype wire

// [verilog/gcw_sync.sv]
// Two-flop synchroniser for a bus of independent pin levels
`default_nettype none
module gcw_sync
  import gcw_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_PINS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_width_check
    $error("gcw_sync: WIDTH must be at least 1");
  end

  // The first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [verif/gcw_pin_model.sv]
// Model of the devices on the eight pins: pull-ups and optional external drivers
`default_nettype none
module gcw_pin_model
  import gcw_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe_n,
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_val,
  output logic      [NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Block driver wins a clash; a released line nobody drives floats up to one
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the eight-pin port block
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gcw_pkg::*;
  logic                clk_sys;
  logic                rst_n;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic [DATA_W-1:0]   reg_rdata;
  logic                reg_wr;
  logic                reg_rd;
  logic                img_load;
  logic                usb_reset;
  logic                lite_soft_reset;
  logic                reset_protect;
  logic [NUM_PINS-1:0] img_func, img_drive, img_dir, img_level, img_wk_en, img_wk_pol;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, ext_en, ext_val;
  logic                wake_event;
  logic                irq;
  logic [7:0]          f, d, r, l, wk, pol, mask_v;
  logic [31:0]         v, dummy;
  int                  n_fail, checks, cycles;

  gcw_top gcw_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .IMG_LOAD(img_load), .IMG_FUNC(img_func), .IMG_DRIVE(img_drive), .IMG_DIR(img_dir),
    .IMG_LEVEL(img_level), .IMG_WK_EN(img_wk_en), .IMG_WK_POL(img_wk_pol),
    .USB_RESET(usb_reset), .LITE_SOFT_RESET(lite_soft_reset),
    .RESET_PROTECT(reset_protect), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_N(pin_oe_n), .WAKE_EVENT(wake_event), .IRQ(irq));
  gcw_pin_model gcw_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Pins the block drives: GPIO, output, and not an open-drain high
  function automatic logic [7:0] on_e();
    return ~f & r & (d | ~l);
  endfunction
  function automatic logic [7:0] pin_e();
    return (on_e() & d & l) | (~on_e() & (~ext_en | ext_val));
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask

  task automatic pulse(input logic [2:0] k);
    @(posedge clk_sys);
    {img_load, usb_reset, lite_soft_reset} <= k;
    @(posedge clk_sys);
    {img_load, usb_reset, lite_soft_reset} <= 3'b000;
  endtask

  // Reserved bits get junk so that a block storing them shows up on readback
  task automatic put();
    logic [31:0] j;
    j = $urandom();
    wr(PIN_CONFIG_LOWER_OFS, {j[31:16], f[3:0], d[3:0], r[3:0], l[3:0]});
    wr(PIN_CONFIG_UPPER_OFS, {j[3:0], f[7:4], j[7:4], d[7:4], j[11:8], r[7:4],
      j[15:12], l[7:4]});
    wr(PIN_WAKE_ENABLE_POLARITY_OFS, {j[23:16], pol, j[31:24], wk});
  endtask

  task automatic use_img();
    {f, d, r, l, wk, pol} = {img_func, img_drive, img_dir, img_level, img_wk_en, img_wk_pol};
  endtask

  task automatic chk(input string nm);
    logic [31:0] x;
    logic [7:0]  p;
    logic [7:0]  e;
    repeat (4) @(posedge clk_sys);
    p = pin_e();
    e = ~f & ~r & ~(p ^ pol);
    rd(PIN_CONFIG_LOWER_OFS, x);
    `CHK("lower", {16'h0, f[3:0], d[3:0], r[3:0], p[3:0]}, x)
    rd(PIN_CONFIG_UPPER_OFS, x);
    `CHK("upper", {4'h0, f[7:4], 4'h0, d[7:4], 4'h0, r[7:4], 4'h0, p[7:4]}, x)
    rd(PIN_WAKE_ENABLE_POLARITY_OFS, x);
    `CHK("wake reg", {8'h0, pol, 8'h0, wk}, x)
    `CHK("oe_n", ~on_e(), pin_oe_n)
    `CHK("out", on_e() & d & l, pin_out & on_e())
    `CHK("wake", |(e & wk), wake_event)
    wr(PIN_EVENT_STATUS_OFS, 32'hffff_ffff);
    repeat (2) @(posedge clk_sys);
    rd(PIN_EVENT_STATUS_OFS, x);
    `CHK("status", {24'h0, e}, x)
    rd(PIN_EVENT_MASK_OFS, x);
    `CHK("mask", {24'h0, mask_v}, x)
    `CHK("irq", |(e & mask_v), irq)
    $display("test %s done", nm);
  endtask

  // Hang guard: the whole sequence needs roughly 540 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    dummy = $urandom(52);
    {rst_n, reg_wr, reg_rd, img_load, usb_reset, lite_soft_reset, reset_protect} = 7'h00;
    reg_addr = '0;
    reg_wdata = '0;
    {img_func, img_drive, img_dir, img_level, img_wk_en, img_wk_pol} = '0;
    {ext_en, ext_val, mask_v} = '0;
    {f, d, r, l, wk, pol} = {FUNC_DEFAULT, DRIVE_DEFAULT, DIR_DEFAULT, LEVEL_DEFAULT,
      WK_EN_DEFAULT, WK_POL_DEFAULT};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("reset");
    wr(12'h100, $urandom());
    rd(12'h100, v);
    `CHK("unmapped", 32'h0, v)
    $display("test unmapped done");
    {f, d, r, l} = $urandom();
    {wk, pol, ext_en, ext_val} = $urandom();
    put();
    pulse(3'b010);
    {f, d, r, l, wk, pol} = {FUNC_DEFAULT, 40'h0};
    chk("restore defaults");
    for (int i = 0; i < 16; i++) begin
      {f, d, r, l} = $urandom();
      {wk, pol, ext_en, ext_val} = $urandom();
      mask_v = 8'($urandom());
      if (i == 0) begin
        {f, r, wk} = 24'h0000ff;
      end
      if (i == 1) begin
        {f, r, wk} = 24'hff00ff;
      end
      wr(PIN_EVENT_MASK_OFS, {24'h0, mask_v});
      put();
      chk("random");
    end
    @(posedge clk_sys);
    {img_func, img_drive, img_dir, img_level} <= $urandom();
    {img_wk_en, img_wk_pol} <= 16'($urandom());
    pulse(3'b100);
    use_img();
    chk("image load");
    {f, d, r, l} = $urandom();
    put();
    reset_protect <= 1'b1;
    pulse(3'b011);
    chk("protected");
    @(posedge clk_sys);
    reset_protect <= 1'b0;
    pulse(3'b001);
    use_img();
    chk("lite restore");
    close_out();
  end
endmodule
`default_nettype wire
